// ===== hdl/csu_top.sv
// clock source unit: source select, modes, divider and register slave
//
// The placing of the registers and the AHB-Lite interface to the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module csu_top
  import csu_pkg::*;
(
  input wire logic I_CLK,
  input wire logic I_RST_N,
  input wire logic I_HSEL,
  input wire logic [31:0] I_HADDR,
  input wire logic [1:0] I_HTRANS,
  input wire logic I_HWRITE,
  input wire logic [2:0] I_HSIZE,
  input wire logic [31:0] I_HWDATA,
  input wire logic I_HREADY,
  output logic O_HREADYOUT,
  output logic O_HRESP,
  output logic [31:0] O_HRDATA,
  input wire logic I_STOP,
  input wire logic I_FLL_CLK,
  input wire logic I_INT_REF_CLK,
  input wire logic I_EXT_REF_CLK,
  input wire logic I_OSC_READY,
  output logic O_SYS_CLK,
  output logic O_BUS_CLK,
  output logic [2:0] O_MODE,
  output logic O_FLL_EN,
  output logic O_FLL_REF_INT,
  output logic [2:0] O_REF_DIV,
  output logic [8:0] O_TRIM,
  output logic O_INT_REF_EN,
  output logic O_INT_REF_OUT,
  output logic O_INT_REF_STOP_EN,
  output logic O_EXT_REF_EN,
  output logic O_EXT_REF_OUT,
  output logic O_EXT_REF_STOP_EN,
  output logic O_OSC_RANGE,
  output logic O_OSC_HIGH_GAIN,
  output logic O_OSC_REQ
);

  // fastest reference must still be sampled cleanly
  if (REF_SAMPLES < 4) begin : g_ref_chk
    $error("csu_top: clock too slow for the fastest reference");
  end

  typedef struct packed {
    logic [7:0] c1;
    logic [7:0] c2;
    logic [7:0] trm;
    logic fine_adj;
    logic wr_pend;
    logic wr_ok;
    logic [1:0] wr_idx;
    logic hready;
    logic [31:0] hrdata;
    logic [1:0] src_act;
    logic [1:0] div_act;
    logic clr;
    logic sys_prev;
    logic bus_clk;
    logic osc_rdy;
    logic last_int;
    logic last_ext;
    csu_mode_t mode;
    logic fll_en;
    logic int_en;
    logic int_out;
    logic ext_en;
    logic ext_out;
  } csu_state_t;

  localparam csu_state_t RST_S = '{
    c1: CTRL_ONE_RST,
    c2: CTRL_TWO_RST,
    trm: TRIM_RST,
    fine_adj: FINE_ADJ_RST,
    div_act: CTRL_TWO_RST[BUS_DIV_LSB +: 2],
    hready: 1'b1,
    mode: MODE_ENG_INT,
    fll_en: 1'b1,
    last_int: 1'b1,
    default: '0
  };

  csu_state_t s_r;
  csu_state_t s_nxt;

  csu_div_if dv ();

  csu_divider #(
    .CNT_W(3)
  ) u_div (
    .i_clk(I_CLK),
    .i_rst_n(I_RST_N),
    .dv(dv)
  );

  // =====================================================
  // source multiplexer
  // clocks come in as arguments so a continuous assign sees their edges
  function automatic logic pick_src(input logic [1:0] sel, input logic fll,
                                    input logic iref, input logic eref);
    logic v;
    v = 1'b0;
    unique case (sel)
      SRC_INT: v = iref;
      SRC_EXT: v = eref;
      default: v = fll;
    endcase
    return v;
  endfunction

  function automatic logic [7:0] read_reg(input logic [1:0] idx, input csu_state_t st);
    logic [7:0] v;
    v = 8'h00;
    unique case (idx)
      OFS_CTRL_ONE[3:2]: v = st.c1;
      OFS_CTRL_TWO[3:2]: v = st.c2;
      OFS_TRIM[3:2]: v = st.trm;
      OFS_STATUS[3:2]: begin
        v[CLK_STATUS_LSB +: 2] = st.src_act;
        v[OSC_READY_BIT] = st.osc_rdy;
        v[FINE_ADJ_BIT] = st.fine_adj;
      end
    endcase
    return v;
  endfunction

  logic [1:0] src_req;
  logic [1:0] div_req;
  logic loop_off;
  logic int_ref_sel;
  logic uses_int;
  logic uses_ext;
  logic bus_acc;

  always_comb begin
    s_nxt = s_r;
    src_req = 2'b00;
    div_req = 2'b00;
    loop_off = 1'b0;
    int_ref_sel = 1'b0;
    uses_int = 1'b0;
    uses_ext = 1'b0;

    // =====================================================
    // register bus: data phase write
    s_nxt.wr_pend = 1'b0;
    s_nxt.hready = 1'b1;
    if (s_r.wr_pend && s_r.wr_ok) begin
      unique case (s_r.wr_idx)
        OFS_CTRL_ONE[3:2]: begin
          s_nxt.c1 = I_HWDATA[7:0];
          // reserved source code behaves as loop output
          if (I_HWDATA[SRC_SEL_LSB +: 2] == SRC_RSVD) begin
            s_nxt.c1[SRC_SEL_LSB +: 2] = SRC_FLL;
          end
        end
        OFS_CTRL_TWO[3:2]: s_nxt.c2 = I_HWDATA[7:0];
        OFS_TRIM[3:2]: s_nxt.trm = I_HWDATA[7:0];
        OFS_STATUS[3:2]: s_nxt.fine_adj = I_HWDATA[FINE_ADJ_BIT];
      endcase
    end

    // address phase; reads see a write of the cycle before
    bus_acc = I_HSEL && I_HREADY && I_HTRANS[1];
    if (bus_acc) begin
      if (I_HWRITE) begin
        s_nxt.wr_pend = 1'b1;
        s_nxt.wr_ok = (I_HADDR[31:4] == 28'h000_0000);
        s_nxt.wr_idx = I_HADDR[3:2];
      end else if (I_HADDR[31:4] == 28'h000_0000) begin
        s_nxt.hrdata = {24'h00_0000, read_reg(I_HADDR[3:2], s_nxt)};
      end else begin
        s_nxt.hrdata = 32'h0000_0000;
      end
    end

    // =====================================================
    // glitch free source and divider switch
    src_req = s_r.c1[SRC_SEL_LSB +: 2];
    div_req = s_r.c2[BUS_DIV_LSB +: 2];
    s_nxt.clr = 1'b0;
    // switch only with output and new source low
    if (((src_req != s_r.src_act) || (div_req != s_r.div_act)) &&
        !dv.out && !pick_src(src_req, I_FLL_CLK, I_INT_REF_CLK, I_EXT_REF_CLK)) begin
      s_nxt.src_act = src_req;
      s_nxt.div_act = div_req;
      s_nxt.clr = 1'b1;
    end

    // bus clock toggles on each system clock rise
    s_nxt.sys_prev = dv.out;
    if (dv.out && !s_r.sys_prev) begin
      s_nxt.bus_clk = !s_r.bus_clk;
    end
    s_nxt.osc_rdy = I_OSC_READY;

    // =====================================================
    // operating mode
    loop_off = s_r.c2[LOOP_OFF_BIT];
    int_ref_sel = s_r.c1[INT_REF_SEL_BIT];
    // seven modes from stop, source, reference and low power
    if (I_STOP) begin
      s_nxt.mode = MODE_STOP;
    end else begin
      unique case (s_r.src_act)
        SRC_INT: s_nxt.mode = loop_off ? MODE_BYP_INT_LOW : MODE_BYP_INT;
        SRC_EXT: s_nxt.mode = loop_off ? MODE_BYP_EXT_LOW : MODE_BYP_EXT;
        default: s_nxt.mode = int_ref_sel ? MODE_ENG_INT : MODE_ENG_EXT;
      endcase
    end

    // loop runs in engaged and plain bypass modes
    s_nxt.fll_en = (s_nxt.mode == MODE_ENG_INT) || (s_nxt.mode == MODE_ENG_EXT) ||
                   (s_nxt.mode == MODE_BYP_INT) || (s_nxt.mode == MODE_BYP_EXT);
    // loop keeps its reference in plain bypass modes
    uses_int = (s_nxt.fll_en && int_ref_sel) || (s_r.src_act == SRC_INT);
    uses_ext = (s_nxt.fll_en && !int_ref_sel) || (s_r.src_act == SRC_EXT);
    if (!I_STOP) begin
      s_nxt.last_int = (s_nxt.mode == MODE_ENG_INT) || (s_nxt.mode == MODE_BYP_INT) ||
                       (s_nxt.mode == MODE_BYP_INT_LOW);
      s_nxt.last_ext = (s_nxt.mode == MODE_ENG_EXT) || (s_nxt.mode == MODE_BYP_EXT) ||
                       (s_nxt.mode == MODE_BYP_EXT_LOW);
    end

    if (I_STOP) begin
      // references stay only if their stop enable allows
      s_nxt.int_en = s_r.c1[INT_REF_STOP_EN_BIT] &&
                     (s_r.c1[INT_REF_OUT_EN_BIT] || s_r.last_int);
      s_nxt.ext_en = s_r.c2[EXT_REF_STOP_EN_BIT] &&
                     (s_r.c2[EXT_REF_OUT_EN_BIT] || s_r.last_ext);
    end else begin
      s_nxt.int_en = s_r.c1[INT_REF_OUT_EN_BIT] || uses_int;
      s_nxt.ext_en = s_r.c2[EXT_REF_OUT_EN_BIT] || uses_ext;
    end
    s_nxt.int_out = I_INT_REF_CLK && s_r.c1[INT_REF_OUT_EN_BIT] && s_nxt.int_en;
    s_nxt.ext_out = I_EXT_REF_CLK && s_r.c2[EXT_REF_OUT_EN_BIT] && s_nxt.ext_en;
  end

  always_ff @(posedge I_CLK) begin
    // divider select resets to divide by two
    if (!I_RST_N) begin
      s_r <= RST_S;
    end else begin
      s_r <= s_nxt;
    end
  end

  // =====================================================
  // divider hookup; stop holds the output low
  assign dv.src = pick_src(s_r.src_act, I_FLL_CLK, I_INT_REF_CLK, I_EXT_REF_CLK);
  assign dv.div = s_r.div_act;
  assign dv.clr = s_r.clr || (s_r.mode == MODE_STOP);

  // =====================================================
  // outputs, all from flops except O_HRESP, which is tied low
  assign O_HREADYOUT = s_r.hready;
  assign O_HRESP = 1'b0;
  assign O_HRDATA = s_r.hrdata;
  assign O_SYS_CLK = dv.out;
  assign O_BUS_CLK = s_r.bus_clk;
  assign O_MODE = s_r.mode;
  assign O_FLL_EN = s_r.fll_en;
  assign O_FLL_REF_INT = s_r.c1[INT_REF_SEL_BIT];
  assign O_REF_DIV = s_r.c1[REF_DIV_LSB +: 3];
  // eight trim bits plus fine adjust
  assign O_TRIM = {s_r.trm, s_r.fine_adj};
  assign O_INT_REF_EN = s_r.int_en;
  assign O_INT_REF_OUT = s_r.int_out;
  assign O_INT_REF_STOP_EN = s_r.c1[INT_REF_STOP_EN_BIT];
  assign O_EXT_REF_EN = s_r.ext_en;
  assign O_EXT_REF_OUT = s_r.ext_out;
  assign O_EXT_REF_STOP_EN = s_r.c2[EXT_REF_STOP_EN_BIT];
  assign O_OSC_RANGE = s_r.c2[RANGE_BIT];
  assign O_OSC_HIGH_GAIN = s_r.c2[HIGH_GAIN_BIT];
  assign O_OSC_REQ = s_r.c2[EXT_REF_OSC_BIT];

endmodule
`default_nettype wire

// ===== hdl/csu_pkg.sv
// constants and types shared by the clock source unit
`default_nettype none
package csu_pkg;

  // =====================================================
  // register offsets (byte addresses on the register bus)
  localparam logic [3:0] OFS_CTRL_ONE = 4'h0;
  localparam logic [3:0] OFS_CTRL_TWO = 4'h4;
  localparam logic [3:0] OFS_TRIM = 4'h8;
  localparam logic [3:0] OFS_STATUS = 4'hC;

  // =====================================================
  // reset values
  localparam logic [7:0] CTRL_ONE_RST = 8'h04;
  localparam logic [7:0] CTRL_TWO_RST = 8'h40;
  localparam logic [7:0] TRIM_RST = 8'h80;
  localparam logic FINE_ADJ_RST = 1'b0;

  // =====================================================
  // field positions, clock_control_one
  localparam int SRC_SEL_LSB = 6;
  localparam int REF_DIV_LSB = 3;
  localparam int INT_REF_SEL_BIT = 2;
  localparam int INT_REF_OUT_EN_BIT = 1;
  localparam int INT_REF_STOP_EN_BIT = 0;
  // clock_control_two
  localparam int BUS_DIV_LSB = 6;
  localparam int RANGE_BIT = 5;
  localparam int HIGH_GAIN_BIT = 4;
  localparam int LOOP_OFF_BIT = 3;
  localparam int EXT_REF_OSC_BIT = 2;
  localparam int EXT_REF_OUT_EN_BIT = 1;
  localparam int EXT_REF_STOP_EN_BIT = 0;
  // clock_status_control
  localparam int CLK_STATUS_LSB = 2;
  localparam int OSC_READY_BIT = 1;
  localparam int FINE_ADJ_BIT = 0;

  // =====================================================
  // source select codes
  localparam logic [1:0] SRC_FLL = 2'b00;
  localparam logic [1:0] SRC_INT = 2'b01;
  localparam logic [1:0] SRC_EXT = 2'b10;
  localparam logic [1:0] SRC_RSVD = 2'b11;

  // =====================================================
  // timing: sampling rate against fastest reference
  localparam int CLK_KHZ = 40000;
  localparam int REF_MAX_KHZ = 5000;
  localparam int REF_SAMPLES = CLK_KHZ / REF_MAX_KHZ;

  typedef enum logic [2:0] {
    MODE_ENG_INT = 3'b000,
    MODE_ENG_EXT = 3'b001,
    MODE_BYP_INT = 3'b010,
    MODE_BYP_INT_LOW = 3'b011,
    MODE_BYP_EXT = 3'b100,
    MODE_BYP_EXT_LOW = 3'b101,
    MODE_STOP = 3'b110
  } csu_mode_t;

endpackage
`default_nettype wire

// ===== hdl/csu_div_if.sv
// link between the source selector and the output divider
`timescale 1ns/1ps
`default_nettype none
interface csu_div_if;
  logic src;
  logic clr;
  logic [1:0] div;
  logic out;
  modport ctrl (output src, output clr, output div, input out);
  modport divr (input src, input clr, input div, output out);
endinterface
`default_nettype wire

// ===== hdl/csu_divider.sv
// output divider: divides the selected source by 1, 2, 4 or 8
`timescale 1ns/1ps
`default_nettype none
module csu_divider #(
  parameter int CNT_W = 3
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  csu_div_if.divr dv
);

  if (CNT_W < 3) begin : g_cnt_chk
    $error("csu_divider: CNT_W must reach divide by 8");
  end

  typedef struct packed {
    logic src_prev;
    logic [CNT_W-1:0] cnt;
    logic out;
  } csu_div_state_t;

  csu_div_state_t s_r;
  csu_div_state_t s_nxt;

  // =====================================================
  // edge counter
  always_comb begin
    s_nxt = s_r;
    s_nxt.src_prev = dv.src;
    if (dv.clr) begin
      // cleared counter keeps the output low, no runt pulse
      s_nxt.cnt = '0;
      s_nxt.out = 1'b0;
    end else begin
      if (dv.src && !s_r.src_prev) begin
        s_nxt.cnt = s_r.cnt + 1'b1;
      end
      // divide by 1, 2, 4, 8
      unique case (dv.div)
        2'b00: s_nxt.out = dv.src;
        2'b01: s_nxt.out = s_nxt.cnt[0];
        2'b10: s_nxt.out = s_nxt.cnt[1];
        2'b11: s_nxt.out = s_nxt.cnt[2];
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign dv.out = s_r.out;

endmodule
`default_nettype wire

// ===== testbench/csu_checker.sv
// port assertions for the clock source unit
`timescale 1ns/1ps
`default_nettype none
module csu_checker
  import csu_pkg::*;
(
  input wire logic I_CLK,
  input wire logic I_RST_N,
  input wire logic I_HSEL,
  input wire logic [31:0] I_HADDR,
  input wire logic [1:0] I_HTRANS,
  input wire logic I_HWRITE,
  input wire logic [31:0] I_HWDATA,
  input wire logic I_HREADY,
  input wire logic I_STOP,
  input wire logic I_INT_REF_CLK,
  input wire logic I_EXT_REF_CLK,
  input wire logic O_INT_REF_EN,
  input wire logic O_INT_REF_OUT,
  input wire logic O_EXT_REF_EN,
  input wire logic O_EXT_REF_OUT,
  input wire logic O_HREADYOUT,
  input wire logic O_HRESP,
  input wire logic O_SYS_CLK,
  input wire logic O_BUS_CLK,
  input wire logic [2:0] O_MODE,
  input wire logic O_FLL_EN,
  input wire logic O_FLL_REF_INT,
  input wire logic [2:0] O_REF_DIV,
  input wire logic [8:0] O_TRIM,
  input wire logic O_INT_REF_STOP_EN,
  input wire logic O_EXT_REF_STOP_EN,
  input wire logic O_OSC_RANGE,
  input wire logic O_OSC_HIGH_GAIN,
  input wire logic O_OSC_REQ
);
  // ====================
  // write data phase tracking
  logic wv_r;
  logic [3:0] wa_r;
  always_ff @(posedge I_CLK) begin
    wv_r <= I_RST_N && I_HSEL && I_HREADY && I_HTRANS[1] && I_HWRITE
      && I_HADDR[31:4] == 28'h000_0000;
    wa_r <= I_HADDR[3:0];
  end
  default clocking @(posedge I_CLK); endclocking
  default disable iff (!I_RST_N);
  // ====================
  // properties
  a_bus_okay: assert property (O_HREADYOUT && !O_HRESP)
    else $error("bus not ready or not okay");
  a_reset_eng_int: assert property ($rose(I_RST_N) |-> O_MODE == MODE_ENG_INT && O_FLL_EN)
    else $error("reset did not give engaged internal");
  a_ctrl1_write: assert property (wv_r && wa_r == OFS_CTRL_ONE |=>
    O_REF_DIV == $past(I_HWDATA[5:3]) && O_FLL_REF_INT == $past(I_HWDATA[2])
    && O_INT_REF_STOP_EN == $past(I_HWDATA[0])) else $error("ctrl one fields wrong");
  a_osc_ctrl: assert property (wv_r && wa_r == OFS_CTRL_TWO |=>
    O_OSC_RANGE == $past(I_HWDATA[5]) && O_OSC_HIGH_GAIN == $past(I_HWDATA[4])
    && O_OSC_REQ == $past(I_HWDATA[2]) && O_EXT_REF_STOP_EN == $past(I_HWDATA[0]))
    else $error("oscillator controls wrong");
  a_trim_write: assert property (wv_r && wa_r == OFS_TRIM |=>
    O_TRIM[8:1] == $past(I_HWDATA[7:0])) else $error("trim output wrong");
  a_stop_quiet: assert property (I_STOP [*4] |->
    O_MODE == MODE_STOP && !O_SYS_CLK && !O_FLL_EN) else $error("clock runs in stop");
  a_mode_legal: assert property (O_MODE != 3'h7)
    else $error("illegal mode");
  a_lowpwr_loop_off: assert property ((O_MODE == MODE_BYP_INT_LOW ||
    O_MODE == MODE_BYP_EXT_LOW) [*2] |-> !O_FLL_EN)
    else $error("loop on in low power");
  a_int_out_gate: assert property (O_INT_REF_OUT |->
    O_INT_REF_EN && $past(I_INT_REF_CLK)) else $error("internal reference out ungated");
  a_ext_out_gate: assert property (O_EXT_REF_OUT |->
    O_EXT_REF_EN && $past(I_EXT_REF_CLK)) else $error("external reference out ungated");
  a_bus_follow: assert property ($changed(O_BUS_CLK) |->
    $past(O_SYS_CLK, 1) || $past(O_SYS_CLK, 2) || $past(O_SYS_CLK, 3))
    else $error("bus clock moved without system clock");
endmodule
bind csu_top csu_checker u_chk (.*);
`default_nettype wire

// ===== testbench/csu_src_model.sv
// source clocks and oscillator on the far side
`timescale 1ns/1ps
`default_nettype none
module csu_src_model #(
  parameter int FLL_HALF = 2,
  parameter int INT_HALF = 4,
  parameter int EXT_HALF = 5
) (
  input wire logic i_clk,
  output logic o_fll_clk,
  output logic o_int_ref,
  output logic o_ext_ref,
  output logic o_osc_ready
);
  int n = 0;
  always @(posedge i_clk) begin
    n <= n + 1;
    o_fll_clk <= 1'(((n + 1) / FLL_HALF) % 2);
    o_int_ref <= 1'(((n + 1) / INT_HALF) % 2);
    o_ext_ref <= 1'(((n + 1) / EXT_HALF) % 2);
    o_osc_ready <= n > 8;
  end
endmodule
`default_nettype wire

// ===== testbench/tb_fll_clock_source_selector.sv
// self-checking bench for the clock source unit
`timescale 1ns/1ps
`default_nettype none
module tb_fll_clock_source_selector
  import csu_pkg::*;
;
  logic I_CLK, I_RST_N, I_HSEL, I_HWRITE, I_STOP, I_HREADY, O_HREADYOUT, O_HRESP;
  logic [31:0] I_HADDR, I_HWDATA, O_HRDATA, rd_v;
  logic [1:0] I_HTRANS;
  logic [2:0] I_HSIZE, O_MODE, O_REF_DIV;
  logic [8:0] O_TRIM;
  logic I_FLL_CLK, I_INT_REF_CLK, I_EXT_REF_CLK, I_OSC_READY, O_SYS_CLK, O_BUS_CLK;
  logic O_FLL_EN, O_FLL_REF_INT, O_INT_REF_EN, O_INT_REF_OUT, O_INT_REF_STOP_EN;
  logic O_EXT_REF_EN, O_EXT_REF_OUT, O_EXT_REF_STOP_EN, O_OSC_RANGE, O_OSC_HIGH_GAIN;
  logic O_OSC_REQ, rd_ph, chk_ph;
  logic [31:0] expq[$];
  int num_errors = 0;
  int checks = 0;
  int seed = 10;
  assign I_HREADY = O_HREADYOUT;
  csu_top dut (.*);
  csu_src_model src (.i_clk(I_CLK), .o_fll_clk(I_FLL_CLK), .o_int_ref(I_INT_REF_CLK),
    .o_ext_ref(I_EXT_REF_CLK), .o_osc_ready(I_OSC_READY));
  // ====================
  // tasks
  task automatic test_done;
    if (num_errors == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d,
    input logic ck, input logic [31:0] exp);
    I_HSEL <= 1'b1;
    I_HTRANS <= 2'b10;
    I_HADDR <= a;
    I_HWRITE <= w;
    do @(posedge I_CLK); while (!I_HREADY);
    I_HTRANS <= 2'b00;
    I_HWDATA <= d;
    rd_ph <= !w;
    chk_ph <= ck;
    if (!w && ck) expq.push_back(exp);
    do @(posedge I_CLK); while (!I_HREADY);
    rd_v = O_HRDATA;
    rd_ph <= 1'b0;
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    bus(1'b1, a, d, 1'b0, 32'h0000_0000);
  endtask
  task automatic rd(input logic [31:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0000_0000, 1'b1, exp);
  endtask
  // waits for a rising edge of the system (s=0) or bus (s=1) clock
  task automatic edge_up(input logic s);
    int k;
    k = 0;
    while ((s ? O_BUS_CLK : O_SYS_CLK) !== 1'b0 && k < 500) begin
      @(posedge I_CLK);
      k++;
    end
    while ((s ? O_BUS_CLK : O_SYS_CLK) !== 1'b1 && k < 500) begin
      @(posedge I_CLK);
      k++;
    end
  endtask
  task automatic per(input logic s, input int exp);
    time t0;
    edge_up(s);
    t0 = $time;
    edge_up(s);
    cmp(32'(($time - t0) / 25), 32'(exp));
  endtask
  // ====================
  // result watcher
  always @(posedge I_CLK) begin
    if (rd_ph && chk_ph && I_HREADY && expq.size() > 0) cmp(O_HRDATA, expq.pop_front());
  end
  initial begin
    repeat (60000) @(posedge I_CLK);
    num_errors++;
    test_done;
  end
  initial begin
    I_CLK = 1'b0;
    forever #12.5 I_CLK = ~I_CLK;
  end
  // ====================
  // main sequence
  initial begin
    logic [31:0] r;
    logic [1:0] s;
    logic [7:0] c1, c2;
    int h, k;
    {I_RST_N, I_HSEL, I_HWRITE, I_STOP, rd_ph, chk_ph} = 6'h00;
    {I_HADDR, I_HWDATA, I_HTRANS} = 66'h0;
    I_HSIZE = 3'b010;
    repeat (12) @(posedge I_CLK);
    I_RST_N <= 1'b1;
    @(posedge I_CLK);
    cmp(32'(O_MODE), 32'(MODE_ENG_INT));
    rd(OFS_CTRL_ONE, CTRL_ONE_RST);
    rd(OFS_CTRL_TWO, CTRL_TWO_RST);
    rd(OFS_TRIM, TRIM_RST);
    rd(OFS_STATUS, 32'h0000_0002);
    per(1'b0, 8);
    wr(32'h0000_0010, 32'h0000_00FF);
    rd(32'h0000_0010, 32'h0000_0000);
    wr(OFS_CTRL_ONE, 32'h0000_00C4);
    rd(OFS_CTRL_ONE, 32'h0000_0004);
    r = $random(seed);
    wr(OFS_TRIM, {24'h00_0000, r[7:0]});
    rd(OFS_TRIM, {24'h00_0000, r[7:0]});
    wr(OFS_STATUS, 32'h0000_00FD);
    rd(OFS_STATUS, 32'h0000_0003);
    cmp(32'(O_TRIM), {23'h00_0000, r[7:0], 1'b1});
    for (int i = 0; i < 6; i++) begin
      r = $random(seed);
      s = (i < 2) ? SRC_FLL : (i < 4) ? SRC_INT : SRC_EXT;
      h = (i < 2) ? 2 : (i < 4) ? 4 : 5;
      c2 = {r[7:6], r[5:4], i == 3 || i == 5, r[2:0]};
      c1 = {s, r[5:3], i != 1 && i < 4, r[1:0]};
      wr(OFS_CTRL_TWO, 32'(c2));
      wr(OFS_CTRL_ONE, 32'(c1));
      rd(OFS_CTRL_TWO, 32'(c2));
      rd(OFS_CTRL_ONE, 32'(c1));
      k = 0;
      do begin
        bus(1'b0, OFS_STATUS, 32'h0000_0000, 1'b0, 32'h0000_0000);
        k++;
      end while (rd_v[3:2] !== s && k < 100);
      rd(OFS_STATUS, 32'({s, 2'b11}));
      cmp(32'(O_MODE), 32'(i));
      cmp(32'(O_FLL_EN), 32'(i < 3 || i == 4));
      cmp(32'(O_FLL_REF_INT), 32'(c1[2]));
      cmp(32'(O_INT_REF_EN), 32'(c1[1] || i == 0 || i == 2 || i == 3));
      cmp(32'(O_EXT_REF_EN), 32'(c2[1] || i == 1 || i > 3));
      per(1'b0, (2 * h) << c2[7:6]);
      per(1'b1, (4 * h) << c2[7:6]);
    end
    I_STOP <= 1'b1;
    repeat (6) @(posedge I_CLK);
    cmp(32'(O_MODE), 32'(MODE_STOP));
    cmp(32'({O_SYS_CLK, O_FLL_EN}), 32'h0000_0000);
    cmp(32'({O_INT_REF_EN, O_EXT_REF_EN}), 32'({c1[0] && c1[1], c2[0]}));
    I_STOP <= 1'b0;
    repeat (4) @(posedge I_CLK);
    test_done;
  end
endmodule
`default_nettype wire
